// file: peint_board.sv
`timescale 1ns/100ps
module peint_board
  import peint_pkg::*;
(
  input wire logic core_clk,
  input wire peint_pins8_t portAPins,
  input wire peint_pins8_t portBPins,
  input wire peint_pins4_t portDPins,
  input wire logic [19:0] extVal,
  input wire logic [19:0] extEn,
  output logic [7:0] pinAIn,
  output logic [7:0] pinBIn,
  output logic [3:0] pinDIn
);
  // ****************************************************
  // Pin resolution
  // ****************************************************
  logic [19:0] drv;
  logic [19:0] dOut;
  logic [19:0] pu;
  logic [19:0] lvl;
  // A floating line wanders, so a stale level can never pass for a read
  logic [19:0] wig = 20'h5a5a5;
  assign drv = {portAPins.oe, portBPins.oe, portDPins.oe};
  assign dOut = {portAPins.out, portBPins.out, portDPins.out};
  assign pu = {portAPins.pu, portBPins.pu, portDPins.pu};
  assign lvl = (drv & dOut) | (~drv & extEn & extVal) | (~drv & ~extEn & (pu | wig));
  assign {pinAIn, pinBIn, pinDIn} = lvl;
  always @(posedge core_clk)
    wig <= ~wig;
endmodule

// file: peint_pkg.sv
package peint_pkg;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int unsigned CLK_FREQ_HZ = 50000000;
  localparam int unsigned OPT_LOAD_TIME_US = 3000;
  localparam int unsigned OPT_LOAD_CYCLES = OPT_LOAD_TIME_US * (CLK_FREQ_HZ / 1000000);
  localparam int unsigned PU_DELAY_TIME_US = 200;
  localparam int unsigned PU_DELAY_CYCLES = PU_DELAY_TIME_US * (CLK_FREQ_HZ / 1000000);
  localparam int unsigned RES_HOLD_TIME_US = 200;
  localparam int unsigned FILT_DIV_CYCLES = 16;

  // ****************************************************
  // Vectors and reset values
  // ****************************************************
  localparam logic [7:0] VEC_IRQ0 = 8'h03;
  localparam logic [7:0] VEC_IRQ1 = 8'h0b;
  localparam logic [7:0] VEC_IRQ2 = 8'h13;
  localparam logic [7:0] VEC_IRQ3 = 8'h1b;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] PORT_RST = 8'h00;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [1:0] {TRIG_RISE, TRIG_FALL, TRIG_HIGH, TRIG_LOW} peint_lvl_trig_t;
  typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_NONE} peint_edge_trig_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } peint_pins8_t;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
    logic [3:0] pu;
  } peint_pins4_t;

  typedef struct packed {
    logic [7:0] cmosA;
    logic [7:0] cmosB;
  } peint_opt_t;

endpackage

// file: peint_port.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Port A direction set per nibble
// - Port B per-bit direction, switchable pull-up
// - Port D per-bit direction, bit0 pull-up stage
// - Port A/B output form per bit from stored options
// - Port A: open-drain no pull, or CMOS+pull
// - Port B software pull-up in both forms
// - Share A4-7 analog, B0-3 serial, B5-6 PWM
// - D0/D1 are irq zero/one and wake-up
// - D2/D3 are irq two/three, timer events
// - Irq three noise filtered before use
// - Irq zero edge or level, vector 03
// - Irq one edge or level, vector 0b
// - Irq two/three edges only, vectors 13/1b
// - Options load within 3 ms after reset
// - Program starts at zero after loading
// - Drivers off during and at reset release
// - Port A CMOS pull-up delayed after reset
// - Open-drain port A readable in output mode
module peint_port
  import peint_pkg::*;
#(
  parameter int unsigned OPT_LOAD_CYC = OPT_LOAD_CYCLES,
  parameter int unsigned PU_DELAY_CYC = PU_DELAY_CYCLES,
  parameter int unsigned FILT_DIV = FILT_DIV_CYCLES
)(
  input wire logic core_clk,
  input wire logic rstn,
  input wire peint_opt_t optData,
  input wire logic [1:0] dirANibble,
  input wire logic [7:0] outA,
  input wire logic [7:0] dirB,
  input wire logic [7:0] outB,
  input wire logic [7:0] puB,
  input wire logic [3:0] dirD,
  input wire logic [3:0] outD,
  input wire logic [3:0] puD,
  input wire logic [7:0] pinAIn,
  input wire logic [7:0] pinBIn,
  input wire logic [3:0] pinDIn,
  input wire logic [1:0] twoWireSdaOut,
  input wire logic [1:0] twoWireSclOut,
  input wire logic [1:0] twoWireEn,
  input wire logic [1:0] pulseOut,
  input wire logic [1:0] pulseEn,
  input wire logic [1:0] trigZero,
  input wire logic [1:0] trigOne,
  input wire logic [1:0] trigTwo,
  input wire logic [1:0] trigThree,
  input wire logic [3:0] irqClear,
  output peint_pins8_t portAPins,
  output peint_pins8_t portBPins,
  output peint_pins4_t portDPins,
  output logic [7:0] readA,
  output logic [7:0] readB,
  output logic [3:0] readD,
  output logic [3:0] analogIn,
  output logic [1:0] twoWireSdaIn,
  output logic [1:0] twoWireSclIn,
  output logic [3:0] irqPending,
  output logic [7:0] irqVector,
  output logic wakeUp,
  output logic [1:0] timerZeroEventIn,
  output logic cpuRun,
  output logic [15:0] pcStart
);

  // ****************************************************
  // Reset sequencing
  // ****************************************************
  typedef enum logic [1:0] {ST_LOAD, ST_PUWAIT, ST_RUN} peint_seq_t;
  peint_seq_t seq_q;
  logic [31:0] seqCnt_q;
  peint_opt_t opt_q;
  logic optDone;
  logic puAllow;
  assign optDone = (seq_q != ST_LOAD);
  assign puAllow = (seq_q == ST_RUN);

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      seq_q <= ST_LOAD;
      seqCnt_q <= 32'h0;
      opt_q <= '0;
    end
    else
    begin
      case (seq_q)
        ST_LOAD:
        begin
          seqCnt_q <= seqCnt_q + 32'h1;
          if (seqCnt_q == 32'(OPT_LOAD_CYC - 1))
          begin
            opt_q <= optData;
            seqCnt_q <= 32'h0;
            seq_q <= ST_PUWAIT;
          end
        end
        ST_PUWAIT:
        begin
          seqCnt_q <= seqCnt_q + 32'h1;
          if (seqCnt_q == 32'(PU_DELAY_CYC - 1))
            seq_q <= ST_RUN;
        end
        ST_RUN: seq_q <= ST_RUN;
        default: seq_q <= ST_LOAD;
      endcase
    end
  end

  // ****************************************************
  // Pin drive
  // ****************************************************
  // Open-drain bits only pull low, so enable tracks a low data bit
  logic [7:0] dirAW, oeA, drvB, oeB, muxB;
  logic [3:0] oeD;
  assign dirAW = {{4{dirANibble[1]}}, {4{dirANibble[0]}}};
  assign oeA = optDone ? (dirAW & (opt_q.cmosA | ~outA)) : 8'h00;
  assign muxB[0] = twoWireEn[0] ? twoWireSdaOut[0] : outB[0];
  assign muxB[1] = twoWireEn[0] ? twoWireSclOut[0] : outB[1];
  assign muxB[2] = twoWireEn[1] ? twoWireSdaOut[1] : outB[2];
  assign muxB[3] = twoWireEn[1] ? twoWireSclOut[1] : outB[3];
  assign muxB[4] = outB[4];
  assign muxB[5] = pulseEn[0] ? pulseOut[0] : outB[5];
  assign muxB[6] = pulseEn[1] ? pulseOut[1] : outB[6];
  assign muxB[7] = outB[7];
  assign drvB = dirB | {1'b0, pulseEn, 1'b0, {2{twoWireEn[1]}}, {2{twoWireEn[0]}}};
  assign oeB = optDone ? (drvB & (opt_q.cmosB | ~muxB)) : 8'h00;
  // D0 is a pull-up stage: drives low actively, high only via pull-up
  assign oeD = optDone ? (dirD & {3'b111, ~outD[0]}) : 4'h0;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      portAPins <= '0;
      portBPins <= '0;
      portDPins <= '0;
    end
    else
    begin
      portAPins.out <= outA;
      portAPins.oe <= oeA;
      portAPins.pu <= puAllow ? (opt_q.cmosA & ~dirAW) : 8'h00;
      portBPins.out <= muxB;
      portBPins.oe <= oeB;
      portBPins.pu <= optDone ? (puB & ~drvB) : 8'h00;
      portDPins.out <= outD;
      portDPins.oe <= oeD;
      portDPins.pu <= optDone ? (puD & ~dirD | {3'b000, dirD[0] & outD[0]}) : 4'h0;
    end
  end

  // ****************************************************
  // Read back and shared inputs
  // ****************************************************
  // Port A CMOS outputs read the latch; open-drain reads the pin level
  logic [7:0] readAD;
  assign readAD = (dirAW & opt_q.cmosA & outA) | (~(dirAW & opt_q.cmosA) & pinAIn);

  // ****************************************************
  // Irq three noise filter
  // ****************************************************
  // Needs three stable ticks, so pulses shorter than that are lost
  logic [15:0] divCnt_q;
  logic tick;
  logic [2:0] filtSh_q;
  logic irq3Filt_q;
  assign tick = (divCnt_q == 16'(FILT_DIV - 1));

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      divCnt_q <= 16'h0;
      filtSh_q <= 3'b000;
      irq3Filt_q <= 1'b0;
    end
    else
    begin
      divCnt_q <= tick ? 16'h0 : divCnt_q + 16'h1;
      if (tick)
      begin
        filtSh_q <= {filtSh_q[1:0], pinDIn[3]};
        if (filtSh_q == 3'b111)
          irq3Filt_q <= 1'b1;
        else if (filtSh_q == 3'b000)
          irq3Filt_q <= 1'b0;
      end
    end
  end

  // ****************************************************
  // Trigger detection
  // ****************************************************
  logic [3:0] irqIn, irqPrev_q, irqHit, rise, fall;
  assign irqIn = {irq3Filt_q, pinDIn[2:0]};
  assign rise = irqIn & ~irqPrev_q;
  assign fall = ~irqIn & irqPrev_q;

  function automatic logic lvlHit(input logic [1:0] t, input logic r, input logic f, input logic v);
    case (t)
      2'd0: lvlHit = r;
      2'd1: lvlHit = f;
      2'd2: lvlHit = v;
      default: lvlHit = ~v;
    endcase
  endfunction

  function automatic logic edgeHit(input logic [1:0] t, input logic r, input logic f);
    case (t)
      2'd0: edgeHit = r;
      2'd1: edgeHit = f;
      2'd2: edgeHit = r | f;
      default: edgeHit = 1'b0;
    endcase
  endfunction

  assign irqHit[0] = lvlHit(trigZero, rise[0], fall[0], irqIn[0]);
  assign irqHit[1] = lvlHit(trigOne, rise[1], fall[1], irqIn[1]);
  assign irqHit[2] = edgeHit(trigTwo, rise[2], fall[2]);
  assign irqHit[3] = edgeHit(trigThree, rise[3], fall[3]);

  logic [7:0] vecD;
  assign vecD = irqPending[0] ? VEC_IRQ0 : irqPending[1] ? VEC_IRQ1 :
                irqPending[2] ? VEC_IRQ2 : irqPending[3] ? VEC_IRQ3 : 8'h00;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      irqPrev_q <= 4'h0;
      irqPending <= 4'h0;
      irqVector <= 8'h00;
      wakeUp <= 1'b0;
      timerZeroEventIn <= 2'b00;
      readA <= PORT_RST;
      readB <= PORT_RST;
      readD <= 4'h0;
      analogIn <= 4'h0;
      twoWireSdaIn <= 2'b00;
      twoWireSclIn <= 2'b00;
      cpuRun <= 1'b0;
      pcStart <= PC_RESET;
    end
    else
    begin
      irqPrev_q <= irqIn;
      irqPending <= optDone ? ((irqPending & ~irqClear) | irqHit) : 4'h0;
      irqVector <= vecD;
      wakeUp <= optDone & (irqHit[0] | irqHit[1]);
      timerZeroEventIn <= irqIn[3:2];
      readA <= readAD;
      readB <= pinBIn;
      readD <= pinDIn;
      analogIn <= pinAIn[7:4];
      twoWireSdaIn <= {pinBIn[2], pinBIn[0]};
      twoWireSclIn <= {pinBIn[3], pinBIn[1]};
      cpuRun <= optDone;
      pcStart <= PC_RESET;
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  a_drv_off_reset: assert property (@(posedge core_clk)
    !rstn |=> portAPins.oe == 8'h00 && portBPins.oe == 8'h00 && portDPins.oe == 4'h0)
    else $error("drivers on after reset");
  a_run_after_load: assert property (@(posedge core_clk) disable iff (!rstn) cpuRun |-> $past(optDone))
    else $error("cpu ran before options loaded");
  a_pu_a_delay: assert property (@(posedge core_clk) disable iff (!rstn)
    seq_q != ST_RUN |=> portAPins.pu == 8'h00)
    else $error("port A pull-up early");
  a_nibble_dir: assert property (@(posedge core_clk) disable iff (!rstn)
    optDone && dirANibble == 2'b00 |=> portAPins.oe == 8'h00)
    else $error("port A driven in input");
  a_pend_sticky: assert property (@(posedge core_clk) disable iff (!rstn)
    irqPending[2] && !irqClear[2] && optDone |=> irqPending[2])
    else $error("pending lost");
  a_irq2_rise: assert property (@(posedge core_clk) disable iff (!rstn)
    optDone && trigTwo == 2'd0 && rise[2] |=> irqPending[2])
    else $error("irq two edge missed");
  a_irq0_low: assert property (@(posedge core_clk) disable iff (!rstn)
    optDone && trigZero == 2'd3 && !irqIn[0] |=> irqPending[0])
    else $error("irq zero level missed");
  a_vec_one: assert property (@(posedge core_clk) disable iff (!rstn)
    irqPending == 4'b0010 |=> irqVector == VEC_IRQ1)
    else $error("irq one vector wrong");
  a_pwm_mux: assert property (@(posedge core_clk) disable iff (!rstn)
    pulseEn[0] |=> portBPins.out[5] == $past(pulseOut[0]))
    else $error("pwm not on B5");
  a_filter_hold: assert property (@(posedge core_clk) disable iff (!rstn) !tick |=> $stable(irq3Filt_q))
    else $error("filter moved off tick");
  c_load_done: cover property (@(posedge core_clk) disable iff (!rstn) $rose(cpuRun));
  c_irq3_hit: cover property (@(posedge core_clk) disable iff (!rstn) irqHit[3]);
  c_wake: cover property (@(posedge core_clk) disable iff (!rstn) wakeUp);

endmodule

// file: port_and_external_interrupt_bench.sv
`timescale 1ns/100ps
module port_and_external_interrupt_bench;
  import peint_pkg::*;
  // ****************************************************
  // Stimulus and checks
  // ****************************************************
  localparam int LD = 10;
  localparam int PD = 5;
  logic core_clk, rstn, wakeUp, cpuRun, sawWake;
  peint_opt_t optData;
  logic [1:0] dirANibble, twoWireSdaOut, twoWireSclOut, twoWireEn, pulseOut, pulseEn;
  logic [1:0] trigZero, trigOne, trigTwo, trigThree, twoWireSdaIn, twoWireSclIn, timerZeroEventIn;
  logic [7:0] outA, dirB, outB, puB, pinAIn, pinBIn, readA, readB, irqVector;
  logic [3:0] dirD, outD, puD, pinDIn, readD, analogIn, irqClear, irqPending;
  logic [15:0] pcStart;
  logic [19:0] extVal, extEn;
  peint_pins8_t portAPins, portBPins;
  peint_pins4_t portDPins;
  int miscompares, nTests, cyc;

  peint_port #(.OPT_LOAD_CYC(LD), .PU_DELAY_CYC(PD), .FILT_DIV(2)) u_dut (.core_clk, .rstn, .optData,
    .dirANibble, .outA, .dirB, .outB, .puB, .dirD, .outD, .puD, .pinAIn, .pinBIn, .pinDIn,
    .twoWireSdaOut, .twoWireSclOut, .twoWireEn, .pulseOut, .pulseEn, .trigZero, .trigOne,
    .trigTwo, .trigThree, .irqClear, .portAPins, .portBPins, .portDPins, .readA, .readB,
    .readD, .analogIn, .twoWireSdaIn, .twoWireSclIn, .irqPending, .irqVector, .wakeUp,
    .timerZeroEventIn, .cpuRun, .pcStart);
  peint_board u_board (.core_clk, .portAPins, .portBPins, .portDPins, .extVal, .extEn,
    .pinAIn, .pinBIn, .pinDIn);

  initial
  begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (wakeUp === 1'b1)
      sawWake = 1;
    if (cyc == 4000)
    begin
      miscompares++;
      endOfTest();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic endOfTest();
    $display("comparisons=%0d mismatches=%0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic doReset();
    rstn = 0;
    {dirANibble, dirB, dirD} = '1;
    optData = 16'($urandom);
    repeat (10)
    begin
      @(negedge core_clk);
      chk({portAPins.oe, portBPins.oe, portDPins.oe, cpuRun, irqPending}, 0);
    end
    rstn = 1;
    repeat (LD - 2)
    begin
      @(negedge core_clk);
      chk({portAPins.oe, portBPins.oe, portDPins.oe, cpuRun, irqPending}, 0);
    end
    repeat (2) @(negedge core_clk);
    chk(cpuRun, 0);
    @(negedge core_clk);
    {dirANibble, dirB, dirD} = 0;
    chk({cpuRun, pcStart}, 17'h10000);
    chk(portAPins.pu, 0);
    repeat (PD + 3) @(negedge core_clk);
    chk(portAPins.pu, optData.cmosA);
    $display("reset test done");
  endtask

  task automatic portTest();
    logic [63:0] r;
    logic [7:0] dA, oA, oB, pA, pB, dB, mB;
    logic [3:0] oD;
    repeat (40)
    begin
      @(negedge core_clk);
      r = {$urandom, $urandom};
      {dirANibble, outA, dirB, outB, puB} = r[33:0];
      {dirD, outD, puD, pulseOut, twoWireSdaOut, twoWireSclOut} = r[51:34];
      {twoWireEn, pulseEn} = r[55:52];
      extVal = 20'($urandom);
      repeat (4) @(negedge core_clk);
      dA = {{4{dirANibble[1]}}, {4{dirANibble[0]}}};
      dB = dirB | {1'b0, pulseEn, 1'b0, {2{twoWireEn[1]}}, {2{twoWireEn[0]}}};
      mB = {outB[7], (pulseEn[1] ? pulseOut[1] : outB[6]), (pulseEn[0] ? pulseOut[0] : outB[5]), outB[4],
        (twoWireEn[1] ? {twoWireSclOut[1], twoWireSdaOut[1]} : outB[3:2]),
        (twoWireEn[0] ? {twoWireSclOut[0], twoWireSdaOut[0]} : outB[1:0])};
      oA = dA & (optData.cmosA | ~outA);
      oB = dB & (optData.cmosB | ~mB);
      oD = {dirD[3:1], dirD[0] & ~outD[0]};
      pA = (oA & outA) | (~oA & extVal[19:12]);
      pB = (oB & mB) | (~oB & extVal[11:4]);
      chk(portAPins.oe, oA);
      chk(portAPins.out, outA);
      chk(portAPins.pu, optData.cmosA & ~dA);
      chk(readA, pA);
      chk(analogIn, pA[7:4]);
      chk(portBPins.oe, oB);
      chk(portBPins.pu, puB & ~dB);
      chk(readB, pB);
      chk({twoWireSdaIn, twoWireSclIn}, {pB[2], pB[0], pB[3], pB[1]});
      chk(portBPins.out, mB);
      chk(portDPins.oe, oD);
      chk(portDPins.out, outD);
      chk(portDPins.pu, (puD & ~dirD) | {3'h0, dirD[0] & outD[0]});
      chk(readD, (oD & outD) | (~oD & extVal[3:0]));
    end
    $display("port test done");
  endtask

  task automatic irqTest();
    logic s, x, y;
    {dirD, extVal} = 0;
    for (int i = 0; i < 4; i++)
      for (int m = 0; m < 4; m++)
        for (int k = 0; k < 2; k++)
        begin
          s = k[0];
          x = m == 0 ? ~s : m == 1 ? s : (i < 2 || m == 2);
          y = i < 2 && m == 2 ? s : i < 2 && m == 3 ? ~s : 1'b0;
          @(negedge core_clk);
          {trigZero, trigOne, trigTwo, trigThree} = 8'(m) << (2 * (3 - i));
          extVal[3:0] = {3'h0, s} << i;
          irqClear = 4'hf;
          repeat (12) @(negedge core_clk);
          irqClear = 0;
          repeat (3) @(negedge core_clk);
          chk(irqPending, {3'h0, y} << i);
          sawWake = 0;
          extVal[3:0] = {3'h0, ~s} << i;
          repeat (12) @(negedge core_clk);
          chk(irqPending, {3'h0, x} << i);
          chk(irqVector, x ? 8'h03 + 8'(i * 8) : 8'h00);
          chk(timerZeroEventIn, i == 2 ? {1'b0, ~s} : i == 3 ? {~s, 1'b0} : 2'b0);
          if (i < 2 && m < 2)
            chk(sawWake, x);
        end
    $display("interrupt test done");
  endtask

  initial
  begin
    {rstn, dirANibble, outA, dirB, outB, puB, dirD, outD, puD, irqClear} = 0;
    {twoWireSdaOut, twoWireSclOut, twoWireEn, pulseOut, trigZero, trigOne, trigTwo, trigThree} = 0;
    {miscompares, nTests, cyc} = 0;
    {sawWake, extVal} = 0;
    optData = 0;
    pulseEn = 2'b11;
    extEn = '1;
    void'($urandom(99034));
    doReset();
    portTest();
    irqTest();
    doReset();
    portTest();
    endOfTest();
  end
endmodule
